// >>> include/sat_pkg.sv
// Shared constants and types for the secondary audio port transmit slot mapper
package sat_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_FORMAT = 8'h1a;
  localparam logic [7:0] ADDR_FILL = 8'h1b;
  localparam logic [7:0] ADDR_MSB_DELAY = 8'h1c;
  localparam logic [7:0] ADDR_PIN_PICK = 8'h1d;
  localparam logic [7:0] ADDR_CHAN1 = 8'h1e;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  // Field positions
  localparam int FMT_LSB = 6;
  localparam int LEN_LSB = 4;
  localparam int FILL_BIT = 6;
  localparam int EN_BIT = 5;
  localparam int HALF_BIT = 4;
  localparam int RUN_BIT = 7;
  // Reset values
  localparam logic [1:0] FMT_RST = 2'h0;
  localparam logic [1:0] LEN_RST = 2'h3;
  localparam logic [4:0] DELAY_RST = 5'h00;
  localparam logic [7:0] PICK_RST = 8'h00;
  localparam logic [4:0] SLOT_RST = 5'h00;
  localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;
  // Bit and slot counting
  localparam logic [5:0] SLOT_LAST_16 = 6'h0f;
  localparam logic [5:0] SLOT_LAST_20 = 6'h13;
  localparam logic [5:0] SLOT_LAST_24 = 6'h17;
  localparam logic [5:0] SLOT_LAST_32 = 6'h1f;
  localparam logic [5:0] SLOT_END = 6'h20;
  localparam logic [5:0] MSB_INDEX = 6'h1f;

  typedef enum logic [1:0] {
    SAT_FMT_TDM = 2'b00,
    SAT_FMT_I2S = 2'b01,
    SAT_FMT_LEFT_JUST = 2'b10,
    SAT_FMT_UNUSED = 2'b11
  } sat_fmt_t;

  typedef struct packed {
    sat_fmt_t fmt;
    logic [1:0] slot_len;
    logic idle_fill;
    logic [4:0] msb_delay;
    logic [7:0] pin_pick;
    logic chan1_enable;
    logic [4:0] chan1_slot;
  } sat_cfg_t;

  typedef struct packed {
    sat_cfg_t cfg;
    logic [31:0] sample;
  } sat_xfer_t;

  // Index of the last bit cycle in one slot
  function automatic logic [5:0] sat_slot_last(input logic [1:0] len);
    logic [5:0] last;
    last = SLOT_LAST_32;
    unique case (len)
      2'h0: last = SLOT_LAST_16;
      2'h1: last = SLOT_LAST_20;
      2'h2: last = SLOT_LAST_24;
      2'h3: last = SLOT_LAST_32;
    endcase
    return last;
  endfunction : sat_slot_last
endpackage : sat_pkg

// >>> verilog/sat_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sat_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [W-1:0] async_in, // Level from another domain
  output logic [W-1:0] sync_out // Synchronised level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = rst ? '0 : async_in;
    sync_d = rst ? '0 : meta_q;
  end

  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;
endmodule : sat_sync

// >>> verilog/sat_tx_top.sv
// Secondary audio port transmit slot mapper: registers, crossing and serial output
// Functional notes
// - A 5-bit delay field holds the MSB of slot 0 back by that many bit clocks, 0 to 31, reset 0.
// - The delay acts on both data pins and on slot 0 of the TDM frame or of both halves of the frame.
// - Eight pin-pick bits, bit n-1 for channel n, send a channel to the primary pin at 0 or secondary at 1.
// - Channel 1 leaves its slot undriven while its enable bit is 0 and sends its sample when 1.
// - In TDM framing channel 1 occupies the slot numbered by its 5-bit slot field, 0 to 31.
// - In I2S or left-justified framing slot values 0-15 are left slots 0-15 and 16-31 right slots 0-15.
// - Bit cycles that no channel owns are driven low or left undriven, by the idle fill bit.
// - A 2-bit length field picks 16, 20, 24 or 32 bit cycles per slot for slot counting.
`timescale 1ns/1ps
module sat_tx_top (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [31:0] chan1_sample, // Converter channel 1 sample, MSB aligned
  input wire logic chan1_sample_valid, // Sample strobe
  input wire logic clk_bit, // Link bit clock from the host
  input wire logic frame_sync, // Frame sync, on clk_bit
  output logic primary_serial_out, // Primary data pin level
  output logic primary_serial_oe, // Primary data pin drive enable
  output logic secondary_serial_out, // Secondary data pin level
  output logic secondary_serial_oe // Secondary data pin drive enable
);
  // System domain
  sat_pkg::sat_cfg_t cfg_q;
  sat_pkg::sat_cfg_t cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [31:0] smp_q;
  logic [31:0] smp_d;
  sat_pkg::sat_xfer_t xfer_q;
  sat_pkg::sat_xfer_t xfer_d;
  logic req_q;
  logic req_d;
  logic [6:0] frm_cnt_q;
  logic [6:0] frm_cnt_d;
  logic frm_seen_q;
  logic frm_seen_d;
  logic run_seen_q;
  logic run_seen_d;
  logic [1:0] back_s;
  logic ack_tgl;
  logic frm_tgl;

  // Link domain
  logic rst_link;
  logic req_s;
  sat_pkg::sat_xfer_t sh_q;
  sat_pkg::sat_xfer_t sh_d;
  logic ack_q;
  logic ack_d;
  logic fs_prev_q;
  logic fs_prev_d;
  logic run_q;
  logic run_d;
  logic right_q;
  logic right_d;
  logic [5:0] skip_q;
  logic [5:0] skip_d;
  logic [5:0] bitc_q;
  logic [5:0] bitc_d;
  logic [5:0] slot_q;
  logic [5:0] slot_d;
  logic frm_q;
  logic frm_d;
  logic [1:0] out_q;
  logic [1:0] out_d;
  logic [1:0] oe_q;
  logic [1:0] oe_d;

  sat_sync #(
    .W(2)
  ) u_back_sync (
    .clk(clk_sys),
    .rst(sys_rst),
    .async_in({frm_q, ack_q}),
    .sync_out(back_s)
  );

  assign ack_tgl = back_s[0];
  assign frm_tgl = back_s[1];

  // Register writes, reads and sample capture
  always_comb
  begin
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    smp_d = smp_q;
    if (chan1_sample_valid)
    begin
      smp_d = chan1_sample;
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        sat_pkg::ADDR_FORMAT:
        begin
          cfg_d.fmt = sat_pkg::sat_fmt_t'(reg_wdata[sat_pkg::FMT_LSB +: 2]);
          cfg_d.slot_len = reg_wdata[sat_pkg::LEN_LSB +: 2];
        end
        sat_pkg::ADDR_FILL: cfg_d.idle_fill = reg_wdata[sat_pkg::FILL_BIT];
        sat_pkg::ADDR_MSB_DELAY: cfg_d.msb_delay = reg_wdata[4:0];
        sat_pkg::ADDR_PIN_PICK: cfg_d.pin_pick = reg_wdata;
        sat_pkg::ADDR_CHAN1:
        begin
          cfg_d.chan1_enable = reg_wdata[sat_pkg::EN_BIT];
          cfg_d.chan1_slot = reg_wdata[4:0];
        end
        default: cfg_d = cfg_q;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        sat_pkg::ADDR_FORMAT: rdata_d = {cfg_q.fmt, cfg_q.slot_len, 4'h0};
        sat_pkg::ADDR_FILL: rdata_d = {1'b0, cfg_q.idle_fill, 6'h00};
        sat_pkg::ADDR_MSB_DELAY: rdata_d = {3'h0, cfg_q.msb_delay};
        sat_pkg::ADDR_PIN_PICK: rdata_d = cfg_q.pin_pick;
        sat_pkg::ADDR_CHAN1: rdata_d = {2'h0, cfg_q.chan1_enable, cfg_q.chan1_slot};
        sat_pkg::ADDR_STATUS: rdata_d = {run_seen_q, frm_cnt_q};
        default: rdata_d = 8'h00;
      endcase
    end
    if (sys_rst)
    begin
      cfg_d.fmt = sat_pkg::sat_fmt_t'(sat_pkg::FMT_RST);
      cfg_d.slot_len = sat_pkg::LEN_RST;
      cfg_d.idle_fill = 1'b0;
      cfg_d.msb_delay = sat_pkg::DELAY_RST;
      cfg_d.pin_pick = sat_pkg::PICK_RST;
      cfg_d.chan1_enable = 1'b0;
      cfg_d.chan1_slot = sat_pkg::SLOT_RST;
      rdata_d = 8'h00;
      smp_d = sat_pkg::SAMPLE_RST;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    cfg_q <= cfg_d;
    rdata_q <= rdata_d;
    smp_q <= smp_d;
  end

  assign reg_rdata = rdata_q;

  // Word handshake toward the link: a new payload is launched each time the last one is acknowledged
  always_comb
  begin
    xfer_d = xfer_q;
    req_d = req_q;
    if (ack_tgl == req_q)
    begin
      xfer_d.cfg = cfg_q;
      xfer_d.sample = smp_q;
      req_d = ~req_q;
    end
    if (sys_rst)
    begin
      xfer_d = '0;
      req_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    xfer_q <= xfer_d;
    req_q <= req_d;
  end

  // Frame counter for the status register
  always_comb
  begin
    frm_seen_d = frm_tgl;
    frm_cnt_d = frm_cnt_q;
    run_seen_d = run_seen_q;
    if (frm_tgl != frm_seen_q)
    begin
      frm_cnt_d = frm_cnt_q + 7'h01;
      run_seen_d = 1'b1;
    end
    if (sys_rst)
    begin
      frm_seen_d = 1'b0;
      frm_cnt_d = 7'h00;
      run_seen_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    frm_seen_q <= frm_seen_d;
    frm_cnt_q <= frm_cnt_d;
    run_seen_q <= run_seen_d;
  end

  // Link side: reset and request synchronisers
  sat_sync #(
    .W(1)
  ) u_rst_sync (
    .clk(clk_bit),
    .rst(1'b0),
    .async_in(sys_rst),
    .sync_out(rst_link)
  );

  sat_sync #(
    .W(1)
  ) u_req_sync (
    .clk(clk_bit),
    .rst(rst_link),
    .async_in(req_q),
    .sync_out(req_s)
  );

  // Shadow copy of the payload; xfer_q is stable while the request toggle differs from ack
  always_comb
  begin
    sh_d = sh_q;
    ack_d = ack_q;
    if (req_s != ack_q)
    begin
      sh_d = xfer_q;
      ack_d = req_s;
    end
    if (rst_link)
    begin
      sh_d = '0;
      ack_d = 1'b0;
    end
  end

  always_ff @(posedge clk_bit)
  begin
    sh_q <= sh_d;
    ack_q <= ack_d;
  end

  // Frame timing and slot position counters
  logic fs_rise;
  logic fs_fall;
  logic is_tdm;
  logic is_i2s;
  logic start_left;
  logic start_right;
  logic [5:0] slot_last;

  always_comb
  begin
    fs_rise = frame_sync & ~fs_prev_q;
    fs_fall = ~frame_sync & fs_prev_q;
    is_i2s = sh_q.cfg.fmt == sat_pkg::SAT_FMT_I2S;
    is_tdm = (sh_q.cfg.fmt == sat_pkg::SAT_FMT_TDM) || (sh_q.cfg.fmt == sat_pkg::SAT_FMT_UNUSED);
    start_left = is_i2s ? fs_fall : fs_rise;
    start_right = is_tdm ? 1'b0 : (is_i2s ? fs_rise : fs_fall);
    slot_last = sat_pkg::sat_slot_last(sh_q.cfg.slot_len);
    fs_prev_d = frame_sync; // Tracks the pin in reset too, so no false edge follows reset
    run_d = run_q;
    right_d = right_q;
    skip_d = skip_q;
    bitc_d = bitc_q;
    slot_d = slot_q;
    frm_d = frm_q ^ fs_rise;
    if (start_left || start_right)
    begin
      // Delay applies to slot 0 of each half, on both pins; I2S adds its one-bit lag
      skip_d = {1'b0, sh_q.cfg.msb_delay} + {5'h00, is_i2s};
      bitc_d = 6'h00;
      slot_d = 6'h00;
      right_d = start_right;
      run_d = 1'b1;
    end
    else if (skip_q != 6'h00)
    begin
      skip_d = skip_q - 6'h01;
    end
    else if (slot_q != sat_pkg::SLOT_END)
    begin
      if (bitc_q == slot_last)
      begin
        bitc_d = 6'h00;
        slot_d = slot_q + 6'h01;
      end
      else
      begin
        bitc_d = bitc_q + 6'h01;
      end
    end
    if (rst_link)
    begin
      run_d = 1'b0;
      right_d = 1'b0;
      skip_d = 6'h00;
      bitc_d = 6'h00;
      slot_d = sat_pkg::SLOT_END;
      frm_d = 1'b0;
    end
  end

  always_ff @(posedge clk_bit)
  begin
    fs_prev_q <= fs_prev_d;
    run_q <= run_d;
    right_q <= right_d;
    skip_q <= skip_d;
    bitc_q <= bitc_d;
    slot_q <= slot_d;
    frm_q <= frm_d;
  end

  // Slot match for channel 1
  logic active;
  logic in_slot;
  logic data_bit;
  logic [5:0] bit_index;

  always_comb
  begin
    active = run_q && (skip_q == 6'h00) && (slot_q != sat_pkg::SLOT_END);
    if (is_tdm)
    begin
      in_slot = slot_q == {1'b0, sh_q.cfg.chan1_slot};
    end
    else
    begin
      in_slot = (sh_q.cfg.chan1_slot[sat_pkg::HALF_BIT] == right_q)
        && (slot_q == {2'h0, sh_q.cfg.chan1_slot[3:0]});
    end
    in_slot = in_slot && active;
    bit_index = sat_pkg::MSB_INDEX - bitc_q;
    data_bit = sh_q.sample[bit_index[4:0]];
  end

  // Per-pin drive: channel 1 goes to the pin its pick bit names
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    always_comb
    begin
      out_d[p] = 1'b0;
      oe_d[p] = 1'b0;
      if (run_q && !rst_link && in_slot && (sh_q.cfg.pin_pick[0] == 1'(p)))
      begin
        out_d[p] = sh_q.cfg.chan1_enable & data_bit;
        oe_d[p] = sh_q.cfg.chan1_enable;
      end
      else if (run_q && !rst_link)
      begin
        oe_d[p] = ~sh_q.cfg.idle_fill;
      end
    end
  end

  always_ff @(posedge clk_bit)
  begin
    out_q <= out_d;
    oe_q <= oe_d;
  end

  assign primary_serial_out = out_q[0];
  assign primary_serial_oe = oe_q[0];
  assign secondary_serial_out = out_q[1];
  assign secondary_serial_oe = oe_q[1];
endmodule : sat_tx_top

// >>> verification/sat_tx_props.sv
// Port assertions for the transmit slot mapper
`timescale 1ns/1ps
module sat_tx_props (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic clk_bit, // Link bit clock
  input wire logic frame_sync, // Frame sync
  input wire logic primary_serial_oe, // Primary pin enable
  input wire logic secondary_serial_oe // Secondary pin enable
);
  logic seen_q;
  // Set once any frame sync edge has been seen since reset
  always_ff @(posedge clk_bit)
    seen_q <= sys_rst ? 1'b0 : (seen_q | $changed(frame_sync));
  property p_back(logic [7:0] a, logic [7:0] m);
    @(posedge clk_sys) disable iff (sys_rst)
      reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a |=> reg_rdata == ($past(reg_wdata, 2) & m);
  endproperty
  a_delay_back: assert property (p_back(sat_pkg::ADDR_MSB_DELAY, 8'h1f))
    else $error("delay readback wrong");
  a_pick_back: assert property (p_back(sat_pkg::ADDR_PIN_PICK, 8'hff))
    else $error("pin pick readback wrong");
  a_chan1_back: assert property (p_back(sat_pkg::ADDR_CHAN1, 8'h3f))
    else $error("chan1 readback wrong");
  a_fill_back: assert property (p_back(sat_pkg::ADDR_FILL, 8'h40))
    else $error("fill readback wrong");
  a_len_back: assert property (p_back(sat_pkg::ADDR_FORMAT, 8'hf0))
    else $error("format readback wrong");
  a_rsv_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == sat_pkg::ADDR_MSB_DELAY |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits set");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read cycle");
  a_link_quiet: assert property (@(posedge clk_bit) disable iff (sys_rst)
    !seen_q |-> !primary_serial_oe && !secondary_serial_oe) else $error("pin driven before first frame");
  c_status_rd: cover property (@(posedge clk_sys) reg_rd && reg_addr == sat_pkg::ADDR_STATUS);
  c_prim_on: cover property (@(posedge clk_bit) $rose(primary_serial_oe));
  c_sec_on: cover property (@(posedge clk_bit) $rose(secondary_serial_oe));
endmodule : sat_tx_props
bind sat_tx_top sat_tx_props u_props (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .clk_bit, .frame_sync, .primary_serial_oe, .secondary_serial_oe);

// >>> verification/sat_host_model.sv
// Host serial port model: bit clock and frame sync per frame, pin capture
`timescale 1ns/1ps
module sat_host_model (
  output logic clk_bit, // Bit clock, still between frames
  output logic frame_sync, // Frame sync
  input wire logic [3:0] pins // Primary oe, out, secondary oe, out
);
  logic [3:0] cap [0:191];
  initial clk_bit = 1'b0;
  initial frame_sync = 1'b0;
  // Four lead-in cycles at idle level, then 192 bit cycles; halves are 96
  task automatic run_frame(input logic [1:0] fmt);
    for (int i = -4; i < 192; i++)
    begin
      frame_sync = (fmt == 2'h1) ? (i < 0 || i >= 96) : (fmt == 2'h2) ? (i >= 0 && i < 96) : (i == 0);
      #6 clk_bit = 1'b1;
      #6;
      if (i >= 0)
        cap[i] = pins;
      clk_bit = 1'b0;
    end
  endtask : run_frame
endmodule : sat_host_model

// >>> verification/sat_tx_top_tb.sv
// Self-checking bench for the transmit slot mapper
`timescale 1ns/1ps
module sat_tx_top_tb;
  logic clk_sys, sys_rst, reg_wr, reg_rd, chan1_sample_valid, clk_bit, frame_sync;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [31:0] chan1_sample, smp;
  logic primary_serial_out, primary_serial_oe, secondary_serial_out, secondary_serial_oe;
  logic [1:0] fmt, len;
  logic [4:0] d, slot;
  logic en, pick, fill;
  int fail_count, n_checks, cyc;
  sat_tx_top dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan1_sample,
    .chan1_sample_valid, .clk_bit, .frame_sync, .primary_serial_out, .primary_serial_oe,
    .secondary_serial_out, .secondary_serial_oe);
  sat_host_model host (.clk_bit, .frame_sync,
    .pins({primary_serial_oe, primary_serial_out, secondary_serial_oe, secondary_serial_out}));
  always #2.5 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One bus cycle; write data is inverted while no write is made
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] wd);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= w ? wd : ~reg_wdata;
    @(posedge clk_sys);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, 1'b1, a, 8'h00);
    #1;
    check(nm, reg_rdata, e);
  endtask : rd
  task automatic wrd(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] e, input string nm);
    acc(1'b1, 1'b0, a, wd);
    rd(a, e, nm);
  endtask : wrd
  // Expected {oe, out} of pin p in bit cycle i
  function automatic logic [1:0] exp_pin(input int i, input logic p);
    int l;
    int b;
    int s;
    int r;
    logic hf;
    hf = fmt == 2'h1 || fmt == 2'h2;
    l = 16 + 4 * len + 4 * (len == 2'h3);
    b = (hf && i >= 96) ? 96 : 0;
    s = hf ? slot[3:0] : slot;
    r = i - b - 1 - d - (fmt == 2'h1) - s * l;
    if (pick == p && r >= 0 && r < l && (!hf || slot[4] == (b != 0)))
      return en ? {1'b1, smp[31 - r]} : 2'b00;
    return fill ? 2'b00 : 2'b10;
  endfunction : exp_pin
  // Only channel 1 is ever enabled, so no two channels share a slot
  task automatic run_case(input logic [1:0] f, ln, input logic [4:0] dl, sl, input logic e, pk, fl);
    logic [1:0] x;
    fmt = f;
    len = ln;
    d = dl;
    slot = sl;
    en = e;
    pick = pk;
    fill = fl;
    smp = {smp[26:0], smp[31:27]} ^ 32'h6d2b_93c5;
    acc(1'b1, 1'b0, sat_pkg::ADDR_FORMAT, {f, ln, 4'h0});
    acc(1'b1, 1'b0, sat_pkg::ADDR_FILL, {1'b0, fl, 6'h00});
    acc(1'b1, 1'b0, sat_pkg::ADDR_MSB_DELAY, {3'h0, dl});
    acc(1'b1, 1'b0, sat_pkg::ADDR_PIN_PICK, {7'h55, pk});
    acc(1'b1, 1'b0, sat_pkg::ADDR_CHAN1, {2'h0, e, sl});
    chan1_sample <= smp;
    chan1_sample_valid <= 1'b1;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chan1_sample_valid <= 1'b0;
    host.run_frame(f);
    host.run_frame(f);
    for (int i = 1; i < 192; i++)
    begin
      x = exp_pin(i, 1'b0);
      check("primary pin", {6'h00, host.cap[i][3:2] & {1'b1, x[1]}}, {6'h00, x});
      x = exp_pin(i, 1'b1);
      check("secondary pin", {6'h00, host.cap[i][1:0] & {1'b1, x[1]}}, {6'h00, x});
    end
  endtask : run_case
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    chan1_sample = 32'h0000_0000;
    chan1_sample_valid = 1'b0;
    smp = 32'hc6a5_3e91;
    repeat (4) @(posedge clk_sys);
    // The link side resets on bit clock edges, so one frame runs inside reset
    host.run_frame(2'h0);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(sat_pkg::ADDR_FORMAT, 8'h30, "format reset");
    rd(sat_pkg::ADDR_FILL, 8'h00, "fill reset");
    rd(sat_pkg::ADDR_MSB_DELAY, 8'h00, "delay reset");
    rd(sat_pkg::ADDR_PIN_PICK, 8'h00, "pick reset");
    rd(sat_pkg::ADDR_CHAN1, 8'h00, "chan1 reset");
    wrd(sat_pkg::ADDR_MSB_DELAY, 8'hff, 8'h1f, "delay");
    wrd(sat_pkg::ADDR_CHAN1, 8'hff, 8'h3f, "chan1");
    wrd(sat_pkg::ADDR_PIN_PICK, 8'ha5, 8'ha5, "pick");
    wrd(sat_pkg::ADDR_FILL, 8'hff, 8'h40, "fill");
    wrd(sat_pkg::ADDR_FORMAT, 8'hff, 8'hf0, "format");
    wrd(sat_pkg::ADDR_STATUS, 8'hff, 8'h00, "status");
    wrd(8'h55, 8'hff, 8'h00, "unmapped");
    run_case(2'h0, 2'h0, 5'd0, 5'd0, 1'b1, 1'b0, 1'b0);
    run_case(2'h0, 2'h3, 5'd31, 5'd3, 1'b1, 1'b1, 1'b1);
    run_case(2'h3, 2'h1, 5'd5, 5'd6, 1'b1, 1'b0, 1'b0);
    run_case(2'h0, 2'h2, 5'd1, 5'd6, 1'b0, 1'b1, 1'b0);
    run_case(2'h1, 2'h0, 5'd3, 5'd17, 1'b1, 1'b1, 1'b0);
    run_case(2'h2, 2'h0, 5'd31, 5'd2, 1'b1, 1'b0, 1'b1);
    run_case(2'h2, 2'h3, 5'd0, 5'd16, 1'b1, 1'b0, 1'b0);
    run_case(2'h1, 2'h2, 5'd2, 5'd1, 1'b1, 1'b1, 1'b1);
    // Eighteen frame sync rises since reset, frame seen bit set
    rd(sat_pkg::ADDR_STATUS, 8'h92, "status frames");
    report_and_stop();
  end
endmodule : sat_tx_top_tb
